// ---- design/dsjf_defs.svh ----
// constants of the direction switch and jump frequency block
// assumes a 100 MHz clock; frequencies in 0.01 Hz, times as noted
`ifndef DSJF_DEFS_SVH
`define DSJF_DEFS_SVH

// parameter addresses, group in the upper byte, index in the lower
`define DSJF_ADDR_START_FREQ   16'h0101
`define DSJF_ADDR_START_HOLD   16'h0102
`define DSJF_ADDR_DEADZONE     16'h010D
`define DSJF_ADDR_SWITCH_MODE  16'h010E
`define DSJF_ADDR_STOP_SPEED   16'h010F
`define DSJF_ADDR_DETECT_SRC   16'h0110
`define DSJF_ADDR_DETECT_TIME  16'h0111
`define DSJF_ADDR_AVOID_P1     16'h0809
`define DSJF_ADDR_AVOID_W1     16'h080A
`define DSJF_ADDR_AVOID_P2     16'h080B
`define DSJF_ADDR_AVOID_W2     16'h080C
`define DSJF_ADDR_AVOID_P3     16'h080D
`define DSJF_ADDR_AVOID_W3     16'h080E
`define DSJF_ADDR_RUN_FREQ     16'h3000
`define DSJF_ADDR_SET_FREQ     16'h3001

// reset values
`define DSJF_RST_START_FREQ    16'h0032
`define DSJF_RST_START_HOLD    16'h0000
`define DSJF_RST_DEADZONE      16'h0000
`define DSJF_RST_SWITCH_MODE   16'h0001
`define DSJF_RST_STOP_SPEED    16'h0032
`define DSJF_RST_DETECT_SRC    16'h0000
`define DSJF_RST_DETECT_TIME   16'h0032
`define DSJF_RST_AVOID         16'h0000

// upper ends of the setting ranges
`define DSJF_MAX_START_FREQ    16'h1388
`define DSJF_MAX_START_HOLD    16'h01F4
`define DSJF_MAX_DEADZONE      16'h8CA0
`define DSJF_MAX_SWITCH_MODE   16'h0002
`define DSJF_MAX_STOP_SPEED    16'h2710
`define DSJF_MAX_DETECT_SRC    16'h0001
`define DSJF_MAX_DETECT_TIME   16'h2710

// timing: one tick is 0.01 s, a 0.1 s unit is ten ticks
`define DSJF_CLK_HZ            100000000
`define DSJF_TICK_US           10000
`define DSJF_TICK_CYCLES       (`DSJF_TICK_US * (`DSJF_CLK_HZ / 1000000))
`define DSJF_DECI_TICKS        20'h0000A

`endif

// ---- design/dsjf_pkg.sv ----
// types of the direction switch and jump frequency block
// constants live in dsjf_defs.svh
package dsjf_pkg;

   typedef struct packed {
      logic [15:0] start_frequency;
      logic [15:0] start_hold_time;
      logic [15:0] reversal_deadzone_time;
      logic [15:0] reversal_switch_mode;
      logic [15:0] stop_speed;
      logic [15:0] stop_detect_source;
      logic [15:0] stop_detect_time;
      logic [15:0] avoid_point_one;
      logic [15:0] avoid_width_one;
      logic [15:0] avoid_point_two;
      logic [15:0] avoid_width_two;
      logic [15:0] avoid_point_three;
      logic [15:0] avoid_width_three;
   } dsjf_cfg_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dsjf_prm_req_t;

   typedef enum logic [2:0] {
      DSJF_ST_IDLE,
      DSJF_ST_HOLD,
      DSJF_ST_RUN,
      DSJF_ST_STOP,
      DSJF_ST_DEC_SW,
      DSJF_ST_DETECT,
      DSJF_ST_BRAKE,
      DSJF_ST_DEAD
   } dsjf_state_t;

endpackage

// ---- design/dsjf_band.sv ----
// one resonance band: moves a frequency inside the band to a band edge
// assumes center and width are already within the maximum output frequency
`timescale 1ns/100ps
module dsjf_band (
   input  wire logic [15:0] freq_in,
   input  wire logic [15:0] center,
   input  wire logic [15:0] width,
   input  wire logic        accel,
   input  wire logic [15:0] max_freq,
   output logic      [15:0] freq_out
);
   logic [15:0] half_w;
   logic [15:0] lo_edge;
   logic [16:0] hi_sum;
   logic [15:0] hi_edge;

   always_comb begin
      half_w  = {1'b0, width[15:1]};
      // saturate so a wide band near zero cannot wrap
      lo_edge = (center > half_w) ? (center - half_w) : 16'h0000;
      hi_sum  = {1'b0, center} + {1'b0, half_w};
      hi_edge = (hi_sum > {1'b0, max_freq}) ? max_freq : hi_sum[15:0];
      freq_out = freq_in;
      if (center != 16'h0000 && freq_in >= lo_edge && freq_in <= hi_edge) begin
         freq_out = accel ? lo_edge : hi_edge;
      end
   end
endmodule

// ---- design/dsjf_top.sv ----
// direction switch sequencing, start frequency hold and resonance avoidance
// assumes synchronous inputs on clk and a power stage that follows out_freq
//
// Operation
// - mode 0 switches at stop speed point
// - mode 1 switches at starting frequency
// - modes 0/1 decelerate to switch point first
// - feedback below point: deadzone then reverse
// - else detection time, deadzone, then reverse
// - mode 2 decelerates like stop, braking optional
// - mode 2: stop speed or brake done, deadzone
// - deadzone time 0.0..3600.0 s, default 0
// - starting frequency 0..50 Hz, start output
// - hold starting frequency, then ramp up
// - set below starting frequency means standby
// - starting frequency ignores lower limit
// - stop detect by set or feedback speed
// - three bands, all zero disables avoidance
// - accelerating inside band runs at lower edge
// - decelerating inside band runs at upper edge
// - band values 0 up to maximum frequency
`timescale 1ns/100ps
`include "dsjf_defs.svh"
module dsjf_top #(
   parameter int          TICK_CYCLES = `DSJF_TICK_CYCLES,
   parameter logic [15:0] RAMP_STEP   = 16'h000A
) (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire dsjf_pkg::dsjf_prm_req_t prm_req,
   output logic                       prm_ack,
   output logic                [15:0] prm_rdata,
   input  wire logic                  run_cmd,
   input  wire logic                  rev_cmd,
   input  wire logic           [15:0] set_freq,
   input  wire logic           [15:0] fb_freq,
   input  wire logic           [15:0] max_output_frequency,
   input  wire logic           [15:0] lower_limit_freq,
   input  wire logic                  brake_enable,
   input  wire logic                  dc_brake_done,
   output logic                [15:0] out_freq,
   output logic                       out_rev,
   output logic                       out_running,
   output logic                       brake_req,
   output logic                       standby
);
   import dsjf_pkg::*;

   dsjf_cfg_t   cfg_r;
   dsjf_cfg_t   cfg_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic        ack_r;
   logic        ack_nxt;

   dsjf_state_t st_r;
   dsjf_state_t st_nxt;
   logic [15:0] freq_r;
   logic [15:0] freq_nxt;
   logic        rev_r;
   logic        rev_nxt;
   logic        brake_r;
   logic        brake_nxt;
   logic [19:0] wait_r;
   logic [19:0] wait_nxt;
   logic [31:0] tick_cnt_r;
   logic [31:0] tick_cnt_nxt;
   logic        tick;

   logic [15:0] band1_f;
   logic [15:0] band2_f;
   logic [15:0] band3_f;
   logic        accel;
   logic [15:0] run_tgt;
   logic [15:0] sw_point;
   logic        in_range;
   logic        wait_done;

   function automatic logic [15:0] ramp(input logic [15:0] cur,
                                        input logic [15:0] tgt);
      logic [15:0] d;
      d = (cur < tgt) ? (tgt - cur) : (cur - tgt);
      if (d <= RAMP_STEP) begin
         ramp = tgt;
      end else if (cur < tgt) begin
         ramp = cur + RAMP_STEP;
      end else begin
         ramp = cur - RAMP_STEP;
      end
   endfunction

   // parameter writes: an out-of-range value is dropped, the old one stays
   always_comb begin
      cfg_nxt   = cfg_r;
      rdata_nxt = rdata_r;
      ack_nxt   = prm_req.wr | prm_req.rd;
      if (prm_req.wr) begin
         case (prm_req.addr)
            `DSJF_ADDR_START_FREQ: begin
               if (prm_req.wdata <= `DSJF_MAX_START_FREQ) begin
                  cfg_nxt.start_frequency = prm_req.wdata;
               end
            end
            `DSJF_ADDR_START_HOLD: begin
               if (prm_req.wdata <= `DSJF_MAX_START_HOLD) begin
                  cfg_nxt.start_hold_time = prm_req.wdata;
               end
            end
            `DSJF_ADDR_DEADZONE: begin
               if (prm_req.wdata <= `DSJF_MAX_DEADZONE) begin
                  cfg_nxt.reversal_deadzone_time = prm_req.wdata;
               end
            end
            `DSJF_ADDR_SWITCH_MODE: begin
               if (prm_req.wdata <= `DSJF_MAX_SWITCH_MODE) begin
                  cfg_nxt.reversal_switch_mode = prm_req.wdata;
               end
            end
            `DSJF_ADDR_STOP_SPEED: begin
               if (prm_req.wdata <= `DSJF_MAX_STOP_SPEED) begin
                  cfg_nxt.stop_speed = prm_req.wdata;
               end
            end
            `DSJF_ADDR_DETECT_SRC: begin
               if (prm_req.wdata <= `DSJF_MAX_DETECT_SRC) begin
                  cfg_nxt.stop_detect_source = prm_req.wdata;
               end
            end
            `DSJF_ADDR_DETECT_TIME: begin
               if (prm_req.wdata <= `DSJF_MAX_DETECT_TIME) begin
                  cfg_nxt.stop_detect_time = prm_req.wdata;
               end
            end
            `DSJF_ADDR_AVOID_P1: begin
               if (in_range) cfg_nxt.avoid_point_one = prm_req.wdata;
            end
            `DSJF_ADDR_AVOID_W1: begin
               if (in_range) cfg_nxt.avoid_width_one = prm_req.wdata;
            end
            `DSJF_ADDR_AVOID_P2: begin
               if (in_range) cfg_nxt.avoid_point_two = prm_req.wdata;
            end
            `DSJF_ADDR_AVOID_W2: begin
               if (in_range) cfg_nxt.avoid_width_two = prm_req.wdata;
            end
            `DSJF_ADDR_AVOID_P3: begin
               if (in_range) cfg_nxt.avoid_point_three = prm_req.wdata;
            end
            `DSJF_ADDR_AVOID_W3: begin
               if (in_range) cfg_nxt.avoid_width_three = prm_req.wdata;
            end
            default: begin
            end
         endcase
      end
      if (prm_req.rd) begin
         case (prm_req.addr)
            `DSJF_ADDR_START_FREQ:  rdata_nxt = cfg_r.start_frequency;
            `DSJF_ADDR_START_HOLD:  rdata_nxt = cfg_r.start_hold_time;
            `DSJF_ADDR_DEADZONE:    rdata_nxt = cfg_r.reversal_deadzone_time;
            `DSJF_ADDR_SWITCH_MODE: rdata_nxt = cfg_r.reversal_switch_mode;
            `DSJF_ADDR_STOP_SPEED:  rdata_nxt = cfg_r.stop_speed;
            `DSJF_ADDR_DETECT_SRC:  rdata_nxt = cfg_r.stop_detect_source;
            `DSJF_ADDR_DETECT_TIME: rdata_nxt = cfg_r.stop_detect_time;
            `DSJF_ADDR_AVOID_P1:    rdata_nxt = cfg_r.avoid_point_one;
            `DSJF_ADDR_AVOID_W1:    rdata_nxt = cfg_r.avoid_width_one;
            `DSJF_ADDR_AVOID_P2:    rdata_nxt = cfg_r.avoid_point_two;
            `DSJF_ADDR_AVOID_W2:    rdata_nxt = cfg_r.avoid_width_two;
            `DSJF_ADDR_AVOID_P3:    rdata_nxt = cfg_r.avoid_point_three;
            `DSJF_ADDR_AVOID_W3:    rdata_nxt = cfg_r.avoid_width_three;
            `DSJF_ADDR_RUN_FREQ:    rdata_nxt = freq_r;
            `DSJF_ADDR_SET_FREQ:    rdata_nxt = set_freq;
            default:                rdata_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_r.start_frequency        <= `DSJF_RST_START_FREQ;
         cfg_r.start_hold_time        <= `DSJF_RST_START_HOLD;
         cfg_r.reversal_deadzone_time <= `DSJF_RST_DEADZONE;
         cfg_r.reversal_switch_mode   <= `DSJF_RST_SWITCH_MODE;
         cfg_r.stop_speed             <= `DSJF_RST_STOP_SPEED;
         cfg_r.stop_detect_source     <= `DSJF_RST_DETECT_SRC;
         cfg_r.stop_detect_time       <= `DSJF_RST_DETECT_TIME;
         cfg_r.avoid_point_one        <= `DSJF_RST_AVOID;
         cfg_r.avoid_width_one        <= `DSJF_RST_AVOID;
         cfg_r.avoid_point_two        <= `DSJF_RST_AVOID;
         cfg_r.avoid_width_two        <= `DSJF_RST_AVOID;
         cfg_r.avoid_point_three      <= `DSJF_RST_AVOID;
         cfg_r.avoid_width_three      <= `DSJF_RST_AVOID;
         rdata_r                      <= 16'h0000;
         ack_r                        <= 1'b0;
      end else begin
         cfg_r   <= cfg_nxt;
         rdata_r <= rdata_nxt;
         ack_r   <= ack_nxt;
      end
   end

   assign in_range = (prm_req.wdata <= max_output_frequency);

   // band chain; a band with a zero point passes through, so all zero disables it
   assign accel = (set_freq > freq_r);

   dsjf_band u_band1 (
      .freq_in  (set_freq),
      .center   (cfg_r.avoid_point_one),
      .width    (cfg_r.avoid_width_one),
      .accel    (accel),
      .max_freq (max_output_frequency),
      .freq_out (band1_f)
   );

   dsjf_band u_band2 (
      .freq_in  (band1_f),
      .center   (cfg_r.avoid_point_two),
      .width    (cfg_r.avoid_width_two),
      .accel    (accel),
      .max_freq (max_output_frequency),
      .freq_out (band2_f)
   );

   dsjf_band u_band3 (
      .freq_in  (band2_f),
      .center   (cfg_r.avoid_point_three),
      .width    (cfg_r.avoid_width_three),
      .accel    (accel),
      .max_freq (max_output_frequency),
      .freq_out (band3_f)
   );

   always_comb begin
      run_tgt = band3_f;
      if (run_tgt < lower_limit_freq) begin
         run_tgt = lower_limit_freq;
      end
      if (run_tgt > max_output_frequency) begin
         run_tgt = max_output_frequency;
      end
      case (cfg_r.reversal_switch_mode[1:0])
         2'h1:    sw_point = cfg_r.start_frequency;
         default: sw_point = cfg_r.stop_speed;
      endcase
   end

   // 0.01 s tick; counts in ticks keep every wait in one small counter
   always_comb begin
      tick         = (tick_cnt_r == 32'(TICK_CYCLES - 1));
      tick_cnt_nxt = tick ? 32'h00000000 : tick_cnt_r + 32'h00000001;
   end

   assign wait_done = (wait_r == 20'h00000);

   always_comb begin
      st_nxt    = st_r;
      freq_nxt  = freq_r;
      rev_nxt   = rev_r;
      brake_nxt = 1'b0;
      wait_nxt  = (tick && !wait_done) ? wait_r - 20'h00001 : wait_r;
      case (st_r)
         DSJF_ST_IDLE: begin
            freq_nxt = 16'h0000;
            if (run_cmd && set_freq >= cfg_r.start_frequency) begin
               freq_nxt = cfg_r.start_frequency;
               rev_nxt  = rev_cmd;
               wait_nxt = 20'(cfg_r.start_hold_time) * `DSJF_DECI_TICKS;
               st_nxt   = DSJF_ST_HOLD;
            end
         end
         DSJF_ST_HOLD: begin
            if (!run_cmd) begin
               st_nxt = DSJF_ST_STOP;
            end else if (wait_done) begin
               st_nxt = DSJF_ST_RUN;
            end
         end
         DSJF_ST_RUN: begin
            if (!run_cmd) begin
               st_nxt = DSJF_ST_STOP;
            end else if (set_freq < cfg_r.start_frequency) begin
               freq_nxt = 16'h0000;
               st_nxt   = DSJF_ST_IDLE;
            end else if (rev_cmd != rev_r) begin
               st_nxt = DSJF_ST_DEC_SW;
            end else if (tick) begin
               freq_nxt = ramp(freq_r, run_tgt);
            end
         end
         DSJF_ST_STOP: begin
            if (tick) begin
               freq_nxt = ramp(freq_r, 16'h0000);
            end
            if (freq_r == 16'h0000) begin
               st_nxt = DSJF_ST_IDLE;
            end
         end
         DSJF_ST_DEC_SW: begin
            if (!run_cmd) begin
               st_nxt = DSJF_ST_STOP;
            end else if (freq_r > sw_point) begin
               if (tick) begin
                  freq_nxt = ramp(freq_r, sw_point);
               end
            end else if (cfg_r.reversal_switch_mode[1]) begin
               if (brake_enable) begin
                  st_nxt = DSJF_ST_BRAKE;
               end else begin
                  wait_nxt = 20'(cfg_r.reversal_deadzone_time) * `DSJF_DECI_TICKS;
                  st_nxt   = DSJF_ST_DEAD;
               end
            end else if (cfg_r.stop_detect_source[0] && fb_freq < sw_point) begin
               wait_nxt = 20'(cfg_r.reversal_deadzone_time) * `DSJF_DECI_TICKS;
               st_nxt   = DSJF_ST_DEAD;
            end else begin
               wait_nxt = 20'(cfg_r.stop_detect_time);
               st_nxt   = DSJF_ST_DETECT;
            end
         end
         DSJF_ST_DETECT: begin
            if (!run_cmd) begin
               st_nxt = DSJF_ST_STOP;
            end else if (wait_done) begin
               wait_nxt = 20'(cfg_r.reversal_deadzone_time) * `DSJF_DECI_TICKS;
               st_nxt   = DSJF_ST_DEAD;
            end
         end
         DSJF_ST_BRAKE: begin
            brake_nxt = 1'b1;
            freq_nxt  = 16'h0000;
            if (!run_cmd) begin
               brake_nxt = 1'b0;
               st_nxt    = DSJF_ST_IDLE;
            end else if (dc_brake_done) begin
               brake_nxt = 1'b0;
               wait_nxt  = 20'(cfg_r.reversal_deadzone_time) * `DSJF_DECI_TICKS;
               st_nxt    = DSJF_ST_DEAD;
            end
         end
         DSJF_ST_DEAD: begin
            if (!run_cmd) begin
               st_nxt = DSJF_ST_STOP;
            end else if (wait_done) begin
               rev_nxt = rev_cmd;
               st_nxt  = DSJF_ST_RUN;
            end
         end
         default: begin
            st_nxt = DSJF_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r       <= DSJF_ST_IDLE;
         freq_r     <= 16'h0000;
         rev_r      <= 1'b0;
         brake_r    <= 1'b0;
         wait_r     <= 20'h00000;
         tick_cnt_r <= 32'h00000000;
      end else begin
         st_r       <= st_nxt;
         freq_r     <= freq_nxt;
         rev_r      <= rev_nxt;
         brake_r    <= brake_nxt;
         wait_r     <= wait_nxt;
         tick_cnt_r <= tick_cnt_nxt;
      end
   end

   assign prm_ack     = ack_r;
   assign prm_rdata   = rdata_r;
   assign out_freq    = freq_r;
   assign out_rev     = rev_r;
   assign brake_req   = brake_r;
   assign out_running = (st_r != DSJF_ST_IDLE);
   assign standby     = (st_r == DSJF_ST_IDLE);
endmodule

// ---- testbench/dsjf_checker.sv ----
// assertions on the ports of dsjf_top
// bound to dsjf_top; mirrors start frequency, switch mode and stop speed
`timescale 1ns/100ps
`include "dsjf_defs.svh"
module dsjf_checker #(
   parameter int          TICK_CYCLES = 10,
   parameter logic [15:0] RAMP_STEP   = 16'h000A
) (
   input wire logic                    clk,
   input wire logic                    sys_rst,
   input wire dsjf_pkg::dsjf_prm_req_t prm_req,
   input wire logic                    prm_ack,
   input wire logic             [15:0] prm_rdata,
   input wire logic                    run_cmd,
   input wire logic                    rev_cmd,
   input wire logic             [15:0] set_freq,
   input wire logic                    brake_enable,
   input wire logic                    dc_brake_done,
   input wire logic             [15:0] out_freq,
   input wire logic                    out_rev,
   input wire logic                    out_running,
   input wire logic                    brake_req,
   input wire logic                    standby
);
   import dsjf_pkg::*;
   logic [15:0] sf_r, sf_nxt, md_r, md_nxt, ss_r, ss_nxt, pt;
   wire         wr = prm_req.wr;
   wire  [15:0] ad = prm_req.addr;
   wire  [15:0] wd = prm_req.wdata;
   // mirror keeps the device range test, or dropped writes would skew it
   always_comb begin
      sf_nxt = sf_r;
      md_nxt = md_r;
      ss_nxt = ss_r;
      if (wr && ad == `DSJF_ADDR_START_FREQ && wd <= 16'h1388) sf_nxt = wd;
      if (wr && ad == `DSJF_ADDR_SWITCH_MODE && wd <= 16'h0002) md_nxt = wd;
      if (wr && ad == `DSJF_ADDR_STOP_SPEED && wd <= 16'h2710) ss_nxt = wd;
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sf_r <= 16'h0032;
         md_r <= 16'h0001;
         ss_r <= 16'h0032;
      end else begin
         sf_r <= sf_nxt;
         md_r <= md_nxt;
         ss_r <= ss_nxt;
      end
   end
   assign pt = (md_r == 16'h0001) ? sf_r : ss_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_start_ok;
      standby && run_cmd && set_freq >= sf_r;
   endsequence
   sequence s_start_low;
      standby && run_cmd && set_freq < sf_r;
   endsequence
   sequence s_flip;
      $changed(out_rev) && !$past(standby);
   endsequence
   a_start_freq: assert property (s_start_ok |=> out_freq == sf_r && out_running)
      else $error("start frequency not applied");
   a_low_set_idle: assert property (s_start_low |=> standby)
      else $error("low set frequency started the drive");
   a_flip_point: assert property (s_flip |-> $past(out_freq) <= pt)
      else $error("direction changed above switch point");
   a_flip_to_cmd: assert property (s_flip |-> out_rev == $past(rev_cmd))
      else $error("direction differs from request");
   a_ramp_step: assert property (out_running && $past(out_running) |->
      out_freq == 16'h0000 || out_freq == sf_r || (out_freq > $past(out_freq) ?
      out_freq - $past(out_freq) : $past(out_freq) - out_freq) <= RAMP_STEP)
      else $error("output frequency jumped");
   a_brake_mode: assert property (brake_req |-> md_r == 16'h0002 && brake_enable)
      else $error("brake outside mode 2");
   a_brake_end: assert property (brake_req && dc_brake_done |-> ##[1:2] !brake_req)
      else $error("brake held after done");
   a_standby_zero: assert property (standby |-> out_freq == 16'h0000 && !out_running)
      else $error("output in standby");
   a_ack_next: assert property (prm_req.wr || prm_req.rd |=> prm_ack)
      else $error("parameter access not acked");
   a_rdata_hold: assert property (!prm_req.rd && !prm_ack |=> $stable(prm_rdata))
      else $error("read data changed without read");
endmodule
bind dsjf_top dsjf_checker #(.TICK_CYCLES(TICK_CYCLES), .RAMP_STEP(RAMP_STEP)) chk_u (
   .clk(clk), .sys_rst(sys_rst), .prm_req(prm_req), .prm_ack(prm_ack),
   .prm_rdata(prm_rdata), .run_cmd(run_cmd), .rev_cmd(rev_cmd), .set_freq(set_freq),
   .brake_enable(brake_enable), .dc_brake_done(dc_brake_done), .out_freq(out_freq),
   .out_rev(out_rev), .out_running(out_running), .brake_req(brake_req), .standby(standby));

// ---- testbench/dsjf_motor.sv ----
// motor and power stage: speed trails out_freq by a fixed slip
// assumes dsjf_top on the same clock; stuck freezes the speed reading
`timescale 1ns/100ps
module dsjf_motor #(
   parameter logic [15:0] SLIP         = 16'h0014,
   parameter int          BRAKE_CYCLES = 30
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [15:0] out_freq,
   input  wire logic        brake_req,
   input  wire logic        stuck,
   input  wire logic        slow,
   output logic      [15:0] fb_freq,
   output logic             dc_brake_done
);
   int brk_cnt;
   always @(posedge clk) begin
      if (sys_rst) begin
         fb_freq <= 16'h0000;
         brk_cnt <= 0;
         dc_brake_done <= 1'b0;
      end else begin
         if (!stuck) fb_freq <= (out_freq > SLIP) ? out_freq - SLIP : 16'h0000;
         brk_cnt <= brake_req ? brk_cnt + 1 : 0;
         dc_brake_done <= brake_req && brk_cnt >= (slow ? 2 * BRAKE_CYCLES : BRAKE_CYCLES);
      end
   end
endmodule

// ---- testbench/dsjf_top_tb.sv ----
// self-checking bench for dsjf_top with a motor model on out_freq
// assumes ten clocks per tick, so 0.1 s is 100 clocks
`timescale 1ns/100ps
module dsjf_top_tb;
   import dsjf_pkg::*;
   logic clk, sys_rst, prm_ack, run_cmd, rev_cmd, brake_enable, dc_done;
   logic out_rev, out_running, brake_req, standby, stuck, slow;
   logic [15:0] prm_rdata, set_freq, fb_freq, max_f, low_f, out_freq, q;
   dsjf_prm_req_t prm_req;
   int bad_count, total_checks, cyc = 0;
   logic [15:0] adr [13] = '{16'h0101, 16'h0102, 16'h010D, 16'h010E, 16'h010F, 16'h0110,
      16'h0111, 16'h0809, 16'h080A, 16'h080B, 16'h080C, 16'h080D, 16'h080E};
   logic [15:0] dfl [13] = '{16'h0032, 16'h0000, 16'h0000, 16'h0001, 16'h0032, 16'h0000,
      16'h0032, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   dsjf_top #(.TICK_CYCLES(10), .RAMP_STEP(16'h000A)) dut_u (
      .clk(clk), .sys_rst(sys_rst), .prm_req(prm_req), .prm_ack(prm_ack),
      .prm_rdata(prm_rdata), .run_cmd(run_cmd), .rev_cmd(rev_cmd), .set_freq(set_freq),
      .fb_freq(fb_freq), .max_output_frequency(max_f), .lower_limit_freq(low_f),
      .brake_enable(brake_enable), .dc_brake_done(dc_done), .out_freq(out_freq),
      .out_rev(out_rev), .out_running(out_running), .brake_req(brake_req), .standby(standby));
   dsjf_motor mot_u (.clk(clk), .sys_rst(sys_rst), .out_freq(out_freq), .brake_req(brake_req),
      .stuck(stuck), .slow(slow), .fb_freq(fb_freq), .dc_brake_done(dc_done));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL t=%0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // request held over the taking edge, answer read after it, released a cycle apart
   task automatic prm(input logic w, input logic [15:0] a, d, output logic [15:0] q);
      prm_req = '{w, !w, a, d};
      tick(1);
      check({15'h0000, prm_ack}, 16'h0001, "no ack");
      q = prm_rdata;
      prm_req = '0;
      tick(1);
   endtask
   task automatic wait_freq(input logic [15:0] f);
      int n;
      n = 0;
      while (out_freq !== f && n < 3000) begin
         tick(1);
         n++;
      end
      check(out_freq, f, "settled frequency");
   endtask
   task automatic test_regs();
      for (int i = 0; i < 13; i++) begin
         prm(0, adr[i], 16'h0000, q);
         check(q, dfl[i], "reset value");
         prm(1, adr[i], 16'h0001, q);
         prm(1, adr[i], 16'hFFFF, q);
         prm(0, adr[i], 16'h0000, q);
         check(q, 16'h0001, "write or range");
         prm(1, adr[i], dfl[i], q);
      end
      prm(0, 16'h0200, 16'h0000, q);
      check(q, 16'h0000, "unmapped read");
      prm(1, 16'h3001, 16'h1234, q);
      prm(0, 16'h3001, 16'h0000, q);
      check(q, 16'h0055, "read-only word");
   endtask
   task automatic test_start();
      prm(1, 16'h0101, 16'h00C8, q);
      prm(1, 16'h0102, 16'h0001, q);
      low_f = 16'h0190;
      set_freq = 16'h03E8;
      run_cmd = 1'b1;
      tick(1);
      check(out_freq, 16'h00C8, "start frequency");
      tick(85);
      check(out_freq, 16'h00C8, "start hold");
      wait_freq(16'h03E8);
   endtask
   task automatic test_bands();
      prm(1, 16'h0809, 16'h0320, q);
      prm(1, 16'h080A, 16'h00C8, q);
      prm(1, 16'h080B, 16'h0258, q);
      prm(1, 16'h080C, 16'h0064, q);
      set_freq = 16'h0320;
      wait_freq(16'h0384);
      set_freq = 16'h0262;
      wait_freq(16'h028A);
      set_freq = 16'h02EE;
      wait_freq(16'h02BC);
      prm(1, 16'h0809, 16'h0000, q);
      prm(1, 16'h080B, 16'h0000, q);
      set_freq = 16'h0320;
      wait_freq(16'h0320);
      set_freq = 16'h03E8;
      wait_freq(16'h03E8);
   endtask
   task automatic rev_case(input logic [15:0] md, src, input logic stk, brk, slw,
                           input int lo, hi, input logic [15:0] pt);
      logic        seen_brk;
      int          n;
      prm(1, 16'h010E, md, q);
      prm(1, 16'h0110, src, q);
      stuck = stk;
      brake_enable = brk;
      slow = slw;
      rev_cmd = !out_rev;
      seen_brk = 1'b0;
      n = 0;
      while (out_freq > pt && n < 3000) begin
         tick(1);
         n++;
      end
      n = 0;
      while (out_rev !== rev_cmd && n < 3000) begin
         tick(1);
         n++;
         seen_brk |= brake_req;
      end
      check(16'(n >= lo && n <= hi), 16'h0001, "reversal wait");
      check({15'h0000, seen_brk}, {15'h0000, brk}, "brake stage");
      stuck = 1'b0;
      wait_freq(16'h03E8);
   endtask
   task automatic test_reversal();
      low_f = 16'h0000;
      prm(1, 16'h010D, 16'h0001, q);
      prm(1, 16'h0111, 16'h0005, q);
      prm(1, 16'h010F, 16'h0064, q);
      rev_case(16'h0001, 16'h0001, 0, 0, 0, 95, 125, 16'h00C8);
      rev_case(16'h0001, 16'h0001, 1, 0, 0, 145, 175, 16'h00C8);
      rev_case(16'h0000, 16'h0000, 0, 0, 0, 145, 175, 16'h0064);
      rev_case(16'h0002, 16'h0000, 0, 1, 1, 155, 200, 16'h0064);
      rev_case(16'h0002, 16'h0000, 0, 0, 0, 95, 125, 16'h0064);
   endtask
   initial begin
      prm_req = '0;
      {run_cmd, rev_cmd, brake_enable, stuck, slow} = 5'h00;
      set_freq = 16'h0055;
      max_f = 16'h1388;
      low_f = 16'h0000;
      sys_rst = 1'b1;
      bad_count = 0;
      total_checks = 0;
      repeat (20) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      test_regs();
      test_start();
      test_bands();
      run_cmd = 1'b0;
      wait_freq(16'h0000);
      run_cmd = 1'b1;
      wait_freq(16'h03E8);
      test_reversal();
      set_freq = 16'h0064;
      tick(3);
      check({15'h0000, standby}, 16'h0001, "standby on low set");
      tally_and_finish();
   end
endmodule
